//--- common/cmx_regs.vh
/*
 * constants for the clock multiplier control and system clock selector:
 * register offset, field positions, reset value, codes and timing counts.
 * assumes it is included by bare name from the files that use it.
 */
`ifndef CMX_REGS_VH
`define CMX_REGS_VH

// special function register offset and reset value
`define CMX_MULCTL_ADDR 8'hbe
`define CMX_MULCTL_RESET 8'h00

// field positions inside the multiplier control register
`define CMX_MULTIPLIER_ENABLE_BIT 7
`define CMX_MULTIPLIER_INITIALIZE_BIT 6
`define CMX_MULTIPLIER_READY_FLAG_BIT 5
`define CMX_MULTIPLIER_INPUT_SELECT_HI 1
`define CMX_MULTIPLIER_INPUT_SELECT_LO 0

// multiplier input select codes
`define CMX_SEL_INT_HALF 2'h0
`define CMX_SEL_EXT 2'h1
`define CMX_SEL_EXT_HALF 2'h2

// system clock source codes
`define CMX_SRC_INT 2'h0
`define CMX_SRC_EXT 2'h1
`define CMX_SRC_MUL 2'h2

// external oscillator mode field (upper two bits of the three-bit mode)
`define CMX_XMODE_OFF 2'h0
`define CMX_XMODE_CMOS 2'h1
`define CMX_XMODE_RC_C 2'h2
`define CMX_XMODE_XTAL 2'h3

// multiplier gain, and ratio of multiplier output to its selected source
`define CMX_MUL_GAIN 3'h4
`define CMX_RATIO_X2 3'h2
`define CMX_RATIO_X4 3'h4

// cycles from initialize until the multiplier output counts as stable
`define CMX_LOCK_CYCLES 16

`endif

//--- src/cmx_settle_timer.v
/*
 * settle timer: counts a fixed number of clocks after a start pulse and
 * then holds done high until aborted or restarted.
 * assumes start and abort come from logic on the same clock.
 */
`timescale 1ns/1ps

module cmx_settle_timer #(
	parameter CYCLES = 16,
	parameter WIDTH = 16
)
(
	// clock and reset
	input wire clk,
	input wire rst,
	// control
	input wire start,
	input wire abort,
	// status
	output reg done
);

	reg [WIDTH-1:0] cnt_q;
	reg busy_q;

	// restart wins over abort so a fresh initialize is never lost
	always @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q <= {WIDTH{1'b0}};
			busy_q <= 1'b0;
			done <= 1'b0;
		end
		else if (start)
		begin
			cnt_q <= CYCLES[WIDTH-1:0] - 1'b1;
			busy_q <= 1'b1;
			done <= 1'b0;
		end
		else if (abort)
		begin
			cnt_q <= {WIDTH{1'b0}};
			busy_q <= 1'b0;
			done <= 1'b0;
		end
		else if (busy_q)
		begin
			if (cnt_q == {WIDTH{1'b0}})
			begin
				busy_q <= 1'b0;
				done <= 1'b1;
			end
			else
				cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule // cmx_settle_timer

//--- src/cmx_clock_ctrl.v
/*
 * clock multiplier control register and system clock source selector.
 * holds the multiplier control register on the special function register
 * port, sequences multiplier lock, derives the crystal valid flag and
 * steers the glitch-safe system clock mux select.
 * assumes the oscillators and the multiplier itself are analog blocks
 * outside, driven by the control outputs here; the other oscillator and
 * clock select registers live elsewhere on the same clock and reach this
 * block as plain inputs.
 */
// Functional notes
// - initialize write on enabled multiplier starts lock
// - ready flag read-only, one once stable
// - ready stays zero until lock completes
// - internal oscillator usable right after enable
// - hardware sets crystal valid once settled
// - rc and c modes need no settling
// - source code 01 selects external oscillator
// - external clock stays available for peripherals
// - switch sources only to enabled, settled ones
// - multiplier output four times selected input; MUL_RATIO gives times two for the halved input codes
`timescale 1ns/1ps
`include "cmx_regs.vh"

module cmx_clock_ctrl #(
	parameter LOCK_CYCLES = `CMX_LOCK_CYCLES,
	parameter LOCK_WIDTH = 16
)
(
	// clock and reset
	input wire CLK,
	input wire RST,
	// special function register port
	input wire [7:0] SFR_ADDR,
	input wire SFR_WR,
	input wire SFR_RD,
	input wire [7:0] SFR_WDATA,
	output reg [7:0] SFR_RDATA,
	// oscillator settings from neighbouring registers
	input wire INT_OSC_EN,
	input wire [2:0] EXT_OSC_MODE,
	input wire [1:0] SYSCLK_SOURCE_SELECT,
	// analog status pin from the crystal amplitude detector
	input wire EXT_OSC_SETTLED,
	// multiplier control to the analog multiplier
	output reg MUL_RUN,
	output reg MUL_LOCK_START,
	output reg MUL_SRC_EXT,
	output reg MUL_SRC_HALF,
	output reg [2:0] MUL_RATIO,
	// oscillator status
	output reg CRYSTAL_VALID_FLAG,
	output reg EXT_CLK_AVAIL,
	// system clock mux
	output reg [1:0] SYSCLK_SRC_ACTIVE,
	output reg SYSCLK_SWITCH_PEND
);

	// two-stage capture of the asynchronous settle pin
	reg settled_meta_q;
	reg settled_q;

	// multiplier control register fields
	reg mul_en_q;
	reg mul_init_q;
	reg [1:0] mul_sel_q;

	wire lock_done;
	wire ctl_wr;
	wire ctl_rd;
	wire init_start;
	wire lock_abort;
	wire mul_ready;
	wire ext_on;
	wire [1:0] xmode;
	reg xtal_valid_d;
	reg src_ok;

	// register reset image, so each field takes its own bits from it
	localparam [7:0] ctl_rst = `CMX_MULCTL_RESET;

	// gain seen from the selected source: halved inputs give times two
	function [2:0] ratio_of;
		input [1:0] sel;
		begin
			if (sel == `CMX_SEL_EXT)
				ratio_of = `CMX_MUL_GAIN;
			else
				ratio_of = `CMX_MUL_GAIN >> 1;
		end
	endfunction

	assign ctl_wr = SFR_WR && (SFR_ADDR == `CMX_MULCTL_ADDR);
	assign ctl_rd = SFR_RD && (SFR_ADDR == `CMX_MULCTL_ADDR);

	// lock starts only when the multiplier was already enabled before this
	// write; a write setting enable and initialize together only sets enable
	assign init_start = ctl_wr && mul_en_q &&
		SFR_WDATA[`CMX_MULTIPLIER_ENABLE_BIT] && SFR_WDATA[`CMX_MULTIPLIER_INITIALIZE_BIT];

	// disabling or changing the input source throws away a finished lock
	assign lock_abort = ctl_wr && (!SFR_WDATA[`CMX_MULTIPLIER_ENABLE_BIT] ||
		(SFR_WDATA[`CMX_MULTIPLIER_INPUT_SELECT_HI:`CMX_MULTIPLIER_INPUT_SELECT_LO] != mul_sel_q));

	// ready needs both the enable and a completed lock count
	assign mul_ready = mul_en_q && lock_done;

	assign xmode = EXT_OSC_MODE[2:1];
	assign ext_on = (xmode != `CMX_XMODE_OFF);

	// lock timer: the multiplier counts as stable after a fixed delay
	cmx_settle_timer #(
		.CYCLES(LOCK_CYCLES),
		.WIDTH(LOCK_WIDTH)
	) u_lock (
		.clk(CLK),
		.rst(RST),
		.start(init_start),
		.abort(lock_abort),
		.done(lock_done)
	);

	// settle pin synchroniser; only the second stage is looked at
	always @(posedge CLK)
	begin
		if (RST)
		begin
			settled_meta_q <= 1'b0;
			settled_q <= 1'b0;
		end
		else
		begin
			settled_meta_q <= EXT_OSC_SETTLED;
			settled_q <= settled_meta_q;
		end
	end

	// control register writes; the ready bit has no storage here
	always @(posedge CLK)
	begin
		if (RST)
		begin
			mul_en_q <= ctl_rst[`CMX_MULTIPLIER_ENABLE_BIT];
			mul_init_q <= ctl_rst[`CMX_MULTIPLIER_INITIALIZE_BIT];
			mul_sel_q <= ctl_rst[`CMX_MULTIPLIER_INPUT_SELECT_HI:`CMX_MULTIPLIER_INPUT_SELECT_LO];
		end
		else if (ctl_wr)
		begin
			mul_en_q <= SFR_WDATA[`CMX_MULTIPLIER_ENABLE_BIT];
			// initialize only sticks on an already running multiplier
			mul_init_q <= init_start;
			mul_sel_q <= SFR_WDATA[`CMX_MULTIPLIER_INPUT_SELECT_HI:`CMX_MULTIPLIER_INPUT_SELECT_LO];
		end
	end

	// read mux; unused bits 4..2 read as zero, ready is live status
	always @(posedge CLK)
	begin
		if (RST)
			SFR_RDATA <= 8'h00;
		else if (ctl_rd)
		begin
			SFR_RDATA <= 8'h00;
			SFR_RDATA[`CMX_MULTIPLIER_ENABLE_BIT] <= mul_en_q;
			SFR_RDATA[`CMX_MULTIPLIER_INITIALIZE_BIT] <= mul_init_q;
			SFR_RDATA[`CMX_MULTIPLIER_READY_FLAG_BIT] <= mul_ready;
			SFR_RDATA[`CMX_MULTIPLIER_INPUT_SELECT_HI:`CMX_MULTIPLIER_INPUT_SELECT_LO] <= mul_sel_q;
		end
		else
			SFR_RDATA <= 8'h00;
	end

	// multiplier drive; code 11 is reserved and treated like code 00
	always @(posedge CLK)
	begin
		if (RST)
		begin
			MUL_RUN <= 1'b0;
			MUL_LOCK_START <= 1'b0;
			MUL_SRC_EXT <= 1'b0;
			MUL_SRC_HALF <= 1'b1;
			MUL_RATIO <= `CMX_RATIO_X2;
		end
		else
		begin
			MUL_RUN <= mul_en_q;
			MUL_LOCK_START <= init_start;
			MUL_SRC_EXT <= (mul_sel_q == `CMX_SEL_EXT) ||
				(mul_sel_q == `CMX_SEL_EXT_HALF);
			MUL_SRC_HALF <= (mul_sel_q != `CMX_SEL_EXT);
			MUL_RATIO <= ratio_of(mul_sel_q);
		end
	end

	// crystal valid: crystal modes wait for the detector, rc and cmos are
	// ready at once; the detector may chatter at start-up, hence the wait
	// software is expected to insert before sampling
	always @*
	begin
		case (xmode)
			`CMX_XMODE_OFF:
				xtal_valid_d = 1'b0;
			`CMX_XMODE_XTAL:
				xtal_valid_d = settled_q;
			`CMX_XMODE_RC_C:
				xtal_valid_d = 1'b1;
			`CMX_XMODE_CMOS:
				xtal_valid_d = 1'b1;
			default:
				xtal_valid_d = 1'b0;
		endcase
	end

	always @(posedge CLK)
	begin
		if (RST)
		begin
			CRYSTAL_VALID_FLAG <= 1'b0;
			EXT_CLK_AVAIL <= 1'b0;
		end
		else
		begin
			CRYSTAL_VALID_FLAG <= xtal_valid_d;
			// peripherals keep the external clock whatever runs the core
			EXT_CLK_AVAIL <= ext_on && xtal_valid_d;
		end
	end

	// is the requested system clock source enabled and settled
	always @*
	begin
		case (SYSCLK_SOURCE_SELECT)
			`CMX_SRC_INT:
				src_ok = INT_OSC_EN;
			`CMX_SRC_EXT:
				src_ok = ext_on && xtal_valid_d;
			`CMX_SRC_MUL:
				src_ok = mul_ready;
			default:
				src_ok = 1'b0;
		endcase
	end

	// on-the-fly switch: the mux only moves to a source that is ready,
	// otherwise it stays on the old one, even when that source has since been disabled or lost its lock
	always @(posedge CLK)
	begin
		if (RST)
		begin
			SYSCLK_SRC_ACTIVE <= `CMX_SRC_INT;
			SYSCLK_SWITCH_PEND <= 1'b0;
		end
		else
		begin
			if (src_ok)
				SYSCLK_SRC_ACTIVE <= SYSCLK_SOURCE_SELECT;
			SYSCLK_SWITCH_PEND <= !src_ok &&
				(SYSCLK_SOURCE_SELECT != SYSCLK_SRC_ACTIVE);
		end
	end

endmodule // cmx_clock_ctrl

//--- test/cmx_checker.sv
/* port assertions for cmx_clock_ctrl.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module cmx_checker #(parameter LOCK_CYCLES = 16)
(
	// clock, reset and inputs
	input wire CLK,
	input wire RST,
	input wire [7:0] SFR_ADDR,
	input wire SFR_WR,
	input wire [7:0] SFR_WDATA,
	input wire INT_OSC_EN,
	input wire [2:0] EXT_OSC_MODE,
	input wire [1:0] SYSCLK_SOURCE_SELECT,
	input wire EXT_OSC_SETTLED,
	// outputs
	input wire MUL_RUN,
	input wire MUL_LOCK_START,
	input wire MUL_SRC_EXT,
	input wire [2:0] MUL_RATIO,
	input wire CRYSTAL_VALID_FLAG,
	input wire [1:0] SYSCLK_SRC_ACTIVE
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);
	// control register write this cycle
	wire ctl_wr = SFR_WR && SFR_ADDR == 8'hbe;
	property p_lock;
		ctl_wr && SFR_WDATA[7:6] == 2'h3 && MUL_RUN |=> MUL_LOCK_START;
	endproperty
	a_lock: assert property (p_lock)
		else $error("no lock start");
	// the run output lags the enable bit by one register stage
	property p_off;
		ctl_wr && !SFR_WDATA[7] |-> ##2 !MUL_RUN;
	endproperty
	a_off: assert property (p_off)
		else $error("still running");
	// ratio and source follow the written select two edges later
	property p_ratio;
		ctl_wr && SFR_WDATA[7] |-> ##2 MUL_RATIO ==
			($past(SFR_WDATA[1:0], 2) == 2'h1 ? 3'h4 : 3'h2) &&
			MUL_SRC_EXT == ($past(SFR_WDATA[1:0], 2) inside {2'h1, 2'h2});
	endproperty
	a_ratio: assert property (p_ratio)
		else $error("bad ratio");
	property p_rc;
		EXT_OSC_MODE[2:1] == 2'h2 |=> CRYSTAL_VALID_FLAG;
	endproperty
	a_rc: assert property (p_rc)
		else $error("rc not valid");
	// synchroniser latency is three edges, four give margin
	property p_xtal;
		(EXT_OSC_MODE[2:1] == 2'h3 && EXT_OSC_SETTLED) [*4]
			|=> CRYSTAL_VALID_FLAG;
	endproperty
	a_xtal: assert property (p_xtal)
		else $error("crystal not valid");
	property p_ext;
		SYSCLK_SOURCE_SELECT == 2'h1 && CRYSTAL_VALID_FLAG
			|=> SYSCLK_SRC_ACTIVE == 2'h1;
	endproperty
	a_ext: assert property (p_ext)
		else $error("no switch to ext");
	property p_int;
		SYSCLK_SOURCE_SELECT == 2'h0 && INT_OSC_EN |=> SYSCLK_SRC_ACTIVE == 2'h0;
	endproperty
	a_int: assert property (p_int)
		else $error("no switch to int");
	// a switch only ever lands on the source that was asked for
	property p_sw;
		$changed(SYSCLK_SRC_ACTIVE) |-> SYSCLK_SRC_ACTIVE ==
			$past(SYSCLK_SOURCE_SELECT);
	endproperty
	a_sw: assert property (p_sw)
		else $error("bad switch");
endmodule // cmx_checker

bind cmx_clock_ctrl cmx_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk (.CLK,
	.RST, .SFR_ADDR, .SFR_WR, .SFR_WDATA, .INT_OSC_EN, .EXT_OSC_MODE,
	.SYSCLK_SOURCE_SELECT, .EXT_OSC_SETTLED, .MUL_RUN, .MUL_LOCK_START,
	.MUL_SRC_EXT, .MUL_RATIO, .CRYSTAL_VALID_FLAG, .SYSCLK_SRC_ACTIVE);

//--- test/clock_multiplier_and_sysclk_select_tb_top.sv
/* self-checking bench for cmx_clock_ctrl.
   assumes the design and cmx_regs.vh are on the search path. */
`timescale 1ns/1ps
`include "cmx_regs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
err_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module clock_multiplier_and_sysclk_select_tb_top;
	localparam L = 4;
	logic CLK = 0, RST = 1, SFR_WR = 0, SFR_RD = 0, EXT_OSC_SETTLED = 0;
	logic INT_OSC_EN = 1;
	logic [7:0] SFR_ADDR = 8'hbe, SFR_WDATA = 8'h00, SFR_RDATA, rd_q;
	logic [2:0] EXT_OSC_MODE = 3'h0, MUL_RATIO;
	logic [1:0] SYSCLK_SOURCE_SELECT = 2'h0, SYSCLK_SRC_ACTIVE;
	logic MUL_RUN, MUL_LOCK_START, MUL_SRC_EXT, MUL_SRC_HALF;
	logic CRYSTAL_VALID_FLAG, EXT_CLK_AVAIL, SYSCLK_SWITCH_PEND;
	int err_count = 0, samples_checked = 0, n;
	cmx_clock_ctrl #(.LOCK_CYCLES(L)) uut (.CLK, .RST, .SFR_ADDR, .SFR_WR,
		.SFR_RD, .SFR_WDATA, .SFR_RDATA, .INT_OSC_EN, .EXT_OSC_MODE,
		.SYSCLK_SOURCE_SELECT, .EXT_OSC_SETTLED, .MUL_RUN, .MUL_LOCK_START,
		.MUL_SRC_EXT, .MUL_SRC_HALF, .MUL_RATIO, .CRYSTAL_VALID_FLAG,
		.EXT_CLK_AVAIL, .SYSCLK_SRC_ACTIVE, .SYSCLK_SWITCH_PEND);
	// inputs move on falling edges, away from the sampling edge
	task cyc(input int k);
		repeat (k) @(negedge CLK);
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(negedge CLK);
		SFR_ADDR = a;
		SFR_WDATA = d;
		SFR_WR = 1;
		@(negedge CLK);
		SFR_WR = 0;
	endtask
	// read data stands one cycle only, so take it at once
	task rd(input [7:0] a);
		@(negedge CLK);
		SFR_ADDR = a;
		SFR_RD = 1;
		@(negedge CLK);
		SFR_RD = 0;
		rd_q = SFR_RDATA;
	endtask
	task final_report;
		$display("mismatches %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		forever #50 CLK = ~CLK;
	end
	// main sequence
	initial
	begin
		cyc(8);
		RST = 0;
		rd(8'hbe);
		`CHK(rd_q, `CMX_MULCTL_RESET)
		wr(8'hbf, 8'h81);
		rd(8'hbf);
		`CHK(rd_q, 8'h00)
		for (int s = 0; s < 4; s++)
		begin
			wr(8'hbe, 8'h80 | 8'(s));
			cyc(1);
			`CHK(MUL_RATIO, s == 1 ? 3'h4 : 3'h2)
			`CHK(MUL_SRC_EXT, s == 1 || s == 2)
			`CHK(MUL_SRC_HALF, s != 1)
		end
		// enable and init together must not start a lock
		wr(8'hbe, 8'h00);
		wr(8'hbe, 8'hc0);
		rd(8'hbe);
		`CHK(rd_q, 8'h80)
		wr(8'hbe, 8'hfc);
		`CHK(MUL_LOCK_START, 1'b1)
		rd(8'hbe);
		`CHK(rd_q, 8'hc0)
		n = 0;
		do
		begin
			rd(8'hbe);
			n++;
		end
		while (rd_q[5] !== 1'b1 && n < 10);
		`CHK(rd_q, 8'he0)
		`CHK(n, 2)
		SYSCLK_SOURCE_SELECT = `CMX_SRC_MUL;
		cyc(1);
		`CHK(SYSCLK_SRC_ACTIVE, `CMX_SRC_MUL)
		SYSCLK_SOURCE_SELECT = 2'h3;
		cyc(2);
		`CHK(SYSCLK_SRC_ACTIVE, `CMX_SRC_MUL)
		SYSCLK_SOURCE_SELECT = `CMX_SRC_INT;
		cyc(1);
		`CHK(SYSCLK_SRC_ACTIVE, `CMX_SRC_INT)
		// disable then re-enable: ready must not come back by itself
		wr(8'hbe, 8'h00);
		wr(8'hbe, 8'h80);
		rd(8'hbe);
		`CHK(rd_q, 8'h80)
		SYSCLK_SOURCE_SELECT = `CMX_SRC_MUL;
		cyc(2);
		`CHK({SYSCLK_SWITCH_PEND, SYSCLK_SRC_ACTIVE}, 3'h4)
		SYSCLK_SOURCE_SELECT = `CMX_SRC_EXT;
		cyc(2);
		`CHK({SYSCLK_SWITCH_PEND, SYSCLK_SRC_ACTIVE}, 3'h4)
		EXT_OSC_MODE = 3'h4;
		cyc(2);
		`CHK(CRYSTAL_VALID_FLAG, 1'b1)
		`CHK(SYSCLK_SRC_ACTIVE, `CMX_SRC_EXT)
		SYSCLK_SOURCE_SELECT = `CMX_SRC_INT;
		EXT_OSC_MODE = 3'h6;
		cyc(6);
		`CHK(CRYSTAL_VALID_FLAG, 1'b0)
		EXT_OSC_SETTLED = 1;
		// software gives the crystal a full millisecond before trusting it
		cyc(10000);
		`CHK({CRYSTAL_VALID_FLAG, EXT_CLK_AVAIL}, 2'h3)
		`CHK(SYSCLK_SRC_ACTIVE, `CMX_SRC_INT)
		// full configure sequence on the settled crystal, times four
		wr(8'hbe, 8'h00);
		wr(8'hbe, 8'h01);
		wr(8'hbe, 8'h81);
		cyc(60);
		wr(8'hbe, 8'hc1);
		n = 0;
		do
		begin
			rd(8'hbe);
			n++;
		end
		while (rd_q[5] !== 1'b1 && n < 10);
		`CHK(rd_q, 8'he1)
		`CHK(MUL_RATIO, `CMX_RATIO_X4)
		SYSCLK_SOURCE_SELECT = `CMX_SRC_MUL;
		cyc(1);
		`CHK(SYSCLK_SRC_ACTIVE, `CMX_SRC_MUL)
		// reset in mid-run drops ready and falls back to the internal clock
		RST = 1;
		cyc(3);
		RST = 0;
		rd(8'hbe);
		`CHK(rd_q, `CMX_MULCTL_RESET)
		`CHK({MUL_RUN, MUL_SRC_HALF, MUL_RATIO}, 5'h0a)
		`CHK({SYSCLK_SWITCH_PEND, SYSCLK_SRC_ACTIVE}, 3'h4)
		final_report;
	end
endmodule // clock_multiplier_and_sysclk_select_tb_top
